// [rtl/nsx_exec.sv]
// How it works
// - Nibble exchange puts f<3:0> into result<7:4> and f<7:4> into result<3:0>, flags untouched.
// - With a destination bit, 0 sends the result to the working register and 1 back to file f (0..127).
// - Port direction load copies the working register to port A, B or C direction for operand 5, 6, 7.
// - Immediate XOR combines the working register with an 8-bit literal into the working register, zero only.
// - File XOR combines the working register with file f to the chosen destination, zero only.
`timescale 1ns/1ps
module nsx_exec
	import nsx_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input nsx_instr_type instr,
	output logic [DATA_W-1:0] wreg,
	output logic zero_flag,
	output nsx_dir_type port_dirs,
	output nsx_fwrite_type fwrite,
	output logic done
);

	// Count of port direction registers
	localparam int N_PORTS = 3;

	// Operand codes per port, port C in the lowest slot like the struct
	localparam logic [N_PORTS*FADDR_W-1:0] DIR_SEL = {PORT_A_SEL, PORT_B_SEL, PORT_C_SEL};

	// Registered state
	nsx_state_type state_ff;

	// Next value of the registered state
	nsx_state_type nxt_state;

	// Instruction valid this cycle
	logic op_live;

	// One-hot operation decode
	logic is_swap;
	logic is_dir_load;
	logic is_xor_imm;
	logic is_xor_file;
	logic op_known;

	// Destination bit decode
	logic dest_file;

	// Operands as seen this cycle
	logic [DATA_W-1:0] w_cur;
	logic [DATA_W-1:0] f_cur;
	logic [DATA_W-1:0] k_cur;

	// Per-operation results
	logic [DATA_W-1:0] swap_res;
	logic [DATA_W-1:0] xor_imm_res;
	logic [DATA_W-1:0] xor_file_res;

	// Selected result and its zero test
	logic [DATA_W-1:0] result;
	logic result_zero;

	// Load enables of the working register, file and flag
	logic w_load;
	logic f_load;
	logic z_load;

	// Direction register select and load per port
	logic [N_PORTS-1:0] dir_hit;
	logic [N_PORTS-1:0] dir_load;

	// Direction registers flattened, current and next
	logic [N_PORTS*DATA_W-1:0] dir_cur;
	logic [N_PORTS*DATA_W-1:0] dir_nxt;

	// Valid qualifies each operation decode below; the destination and operand match decodes do not use it
	assign op_live = instr.valid;

	// Nibble exchange decode
	assign is_swap = op_live && (instr.op == NSX_NIBBLE_EXCHANGE_OP);

	// Direction load decode
	assign is_dir_load = op_live && (instr.op == NSX_PORT_DIRECTION_LOAD_OP);

	// Immediate XOR decode
	assign is_xor_imm = op_live && (instr.op == NSX_XOR_IMMEDIATE_OP);

	// File XOR decode
	assign is_xor_file = op_live && (instr.op == NSX_XOR_FILE_OP);

	// Any executed op; a no-op or an unused code gives no done pulse
	assign op_known = is_swap || is_dir_load || is_xor_imm || is_xor_file;

	// Destination: 1 means back to the file register
	assign dest_file = (instr.dest == DEST_F);

	// Working register as registered before this edge
	assign w_cur = state_ff.wreg;

	// File register content supplied by fetch in the same cycle
	assign f_cur = instr.fdata;

	// Immediate operand
	assign k_cur = instr.literal;

	// Swap the two nibbles of the file operand
	assign swap_res = {f_cur[3:0], f_cur[7:4]};

	// Working register XOR literal
	assign xor_imm_res = w_cur ^ k_cur;

	// Working register XOR file operand
	assign xor_file_res = w_cur ^ f_cur;

	// Result select by operation
	assign result = is_swap ? swap_res : (is_xor_imm ? xor_imm_res : xor_file_res);

	// Zero test over all eight result bits
	assign result_zero = (result == '0);

	// Working register takes immediate XOR, or swap and file XOR with d = 0
	assign w_load = is_xor_imm || ((is_swap || is_xor_file) && !dest_file);

	// File write-back for swap and file XOR with d = 1
	assign f_load = (is_swap || is_xor_file) && dest_file;

	// Only the two XOR ops touch the zero flag, swap leaves it alone
	assign z_load = is_xor_imm || is_xor_file;

	// Current direction registers as one vector
	assign dir_cur = state_ff.dir;

	// One select and load path per direction register
	generate
		for (genvar i = 0; i < N_PORTS; i++)
		begin : g_dir
			// Old content of this port's register
			logic [DATA_W-1:0] old_dir;
			assign old_dir = dir_cur[i*DATA_W +: DATA_W];

			// Operand match for this port
			assign dir_hit[i] = (instr.faddr == DIR_SEL[i*FADDR_W +: FADDR_W]);

			// Load only on a matching direction load
			assign dir_load[i] = is_dir_load && dir_hit[i];

			// Copy the working register or keep the old value
			assign dir_nxt[i*DATA_W +: DATA_W] = dir_load[i] ? w_cur : old_dir;
		end
	endgenerate

	// Next state
	always_comb
	begin
		// Hold everything unless an op says otherwise
		nxt_state = state_ff;

		// Working register load
		if (w_load)
		begin
			nxt_state.wreg = result;
		end

		// Zero flag load
		if (z_load)
		begin
			nxt_state.zero = result_zero;
		end

		// Direction registers, unmatched operands load nothing
		nxt_state.dir = dir_nxt;

		// Write strobe lasts one cycle
		nxt_state.fwrite.we = f_load;

		// Address and data hold their last value between writes
		if (f_load)
		begin
			nxt_state.fwrite.addr = instr.faddr;
			nxt_state.fwrite.data = result;
		end

		// One done pulse per executed op
		nxt_state.done = op_known;
	end

	// State register, synchronous reset
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			// Working register cleared
			state_ff.wreg <= W_RESET;
			// Zero flag cleared
			state_ff.zero <= ZERO_RESET;
			// All port pins start as inputs
			state_ff.dir <= {DIR_RESET, DIR_RESET, DIR_RESET};
			// No write-back pending
			state_ff.fwrite <= '0;
			// No completion pulse
			state_ff.done <= 1'h0;
		end
		else
		begin
			// Normal update
			state_ff <= nxt_state;
		end
	end

	// Working register output
	assign wreg = state_ff.wreg;

	// Zero flag output
	assign zero_flag = state_ff.zero;

	// Direction register outputs
	assign port_dirs = state_ff.dir;

	// File write-back output
	assign fwrite = state_ff.fwrite;

	// Completion pulse output
	assign done = state_ff.done;
endmodule // nsx_exec

// [rtl/nsx_pkg.sv]
package nsx_pkg;
	// Data and operand widths
	localparam int DATA_W = 8;
	localparam int FADDR_W = 7;
	localparam int FADDR_MAX = 127;
	// Port direction load operand codes
	localparam logic [FADDR_W-1:0] PORT_A_SEL = 7'h05;
	localparam logic [FADDR_W-1:0] PORT_B_SEL = 7'h06;
	localparam logic [FADDR_W-1:0] PORT_C_SEL = 7'h07;
	// Destination bit encodings
	localparam logic DEST_W = 1'h0;
	localparam logic DEST_F = 1'h1;
	// Reset values
	localparam logic [DATA_W-1:0] W_RESET = 8'h00;
	localparam logic [DATA_W-1:0] DIR_RESET = 8'hff;
	localparam logic ZERO_RESET = 1'h0;

	// Operation select
	typedef enum logic [2:0] {
		NSX_NOP,
		NSX_NIBBLE_EXCHANGE_OP,
		NSX_PORT_DIRECTION_LOAD_OP,
		NSX_XOR_IMMEDIATE_OP,
		NSX_XOR_FILE_OP
	} nsx_op_type;

	// One instruction handed to the datapath
	typedef struct packed {
		logic valid;
		nsx_op_type op;
		logic dest;
		logic [FADDR_W-1:0] faddr;
		logic [DATA_W-1:0] literal;
		logic [DATA_W-1:0] fdata;
	} nsx_instr_type;

	// File register write-back request
	typedef struct packed {
		logic we;
		logic [FADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} nsx_fwrite_type;

	// Port direction registers
	typedef struct packed {
		logic [DATA_W-1:0] port_a_direction;
		logic [DATA_W-1:0] port_b_direction;
		logic [DATA_W-1:0] port_c_direction;
	} nsx_dir_type;

	// Whole state of the datapath
	typedef struct packed {
		logic [DATA_W-1:0] wreg;
		logic zero;
		nsx_dir_type dir;
		nsx_fwrite_type fwrite;
		logic done;
	} nsx_state_type;
endpackage

// [bench/nsx_exec_sva.sv]
`timescale 1ns/1ps
module nsx_exec_sva
	import nsx_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input nsx_instr_type instr,
	input logic [DATA_W-1:0] wreg,
	input logic zero_flag,
	input nsx_dir_type port_dirs,
	input nsx_fwrite_type fwrite,
	input logic done
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// Live op code, zero when idle
	wire [2:0] o = instr.op & {3{instr.valid}};
	wire d = instr.dest;
	chk_nibble_swap: assert property (
		o == 1 && !d |=> wreg == {$past(instr.fdata[3:0]), $past(instr.fdata[7:4])})
		else $error("swap bad");
	chk_swap_file: assert property (
		o == 1 && d |=> fwrite.we && fwrite.data == {$past(instr.fdata[3:0]),
		$past(instr.fdata[7:4])}) else $error("swap file bad");
	chk_file_dest: assert property (
		o == 4 && d |=> fwrite.we && fwrite.addr == $past(instr.faddr)
		&& fwrite.data == ($past(wreg) ^ $past(instr.fdata))) else $error("xor file bad");
	chk_dir_load: assert property (
		o == 2 && instr.faddr == 7 |=> port_dirs[7:0] == $past(wreg))
		else $error("dir bad");
	chk_xor_lit: assert property (
		o == 3 |=> wreg == ($past(wreg) ^ $past(instr.literal)))
		else $error("xor lit bad");
	chk_zero_hold: assert property (
		o < 3 |=> $stable(zero_flag))
		else $error("zero moved");
	chk_zero_value: assert property (
		o == 3 |=> zero_flag == (wreg == 0))
		else $error("zero bad");
	chk_done_pulse: assert property (
		o != 0 |=> done)
		else $error("done missing");
	chk_done_idle: assert property (
		o == 0 |=> !done)
		else $error("done spurious");
endmodule // nsx_exec_sva
bind nsx_exec nsx_exec_sva chk (.sys_clk(sys_clk), .rst_n(rst_n), .instr(instr), .wreg(wreg),
	.zero_flag(zero_flag), .port_dirs(port_dirs), .fwrite(fwrite), .done(done));

// [bench/nsx_exec_tb.sv]
`timescale 1ns/1ps
module nsx_exec_tb;
	import nsx_pkg::*;
	logic sys_clk = 0, rst_n = 0, zero_flag, z = 0, done;
	nsx_instr_type instr = '0;
	logic [7:0] wreg, w = 0, r;
	nsx_dir_type port_dirs, x = '1;
	nsx_fwrite_type fwrite;
	int n_fail = 0, tests_run = 0;
	nsx_exec dut (.sys_clk(sys_clk), .rst_n(rst_n), .instr(instr), .wreg(wreg),
		.zero_flag(zero_flag), .port_dirs(port_dirs), .fwrite(fwrite), .done(done));
	initial forever #5 sys_clk = ~sys_clk;
	task conclude;
		$display("mismatches %0d checks %0d", n_fail, tests_run);
		if (n_fail == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task chk(logic ok);
		tests_run++;
		if (!ok)
		begin
			n_fail++;
			$display("mismatch %0t outputs differ", $time);
		end
	endtask
	// Expected result of one op
	function automatic logic [7:0] model(logic [2:0] o, logic [23:0] v, logic [7:0] wv);
		return o == 1 ? {v[3:0], v[7:4]} : wv ^ (o[2] ? v[7:0] : v[15:8]);
	endfunction
	// Issue one op at a falling edge, model it, compare one cycle on
	task ex(logic [2:0] o, logic [23:0] v);
		instr <= {1'b1, o, v};
		r = model(o, v, w);
		if (o == 2 && v[22:16] inside {[5:7]}) x[(7 - v[18:16]) * 8 +: 8] = w;
		if (o > 2) z = r == 0;
		@(negedge sys_clk);
		if ((o == 1 || o == 4) && v[23]) chk(fwrite === {1'b1, v[22:16], r});
		else if (o != 2 && o != 0) w = r;
		chk({done, wreg, zero_flag, port_dirs} === {o != 0, w, z, x});
	endtask
	// Reset, corner cases, mid-run reset, then random traffic
	initial
	begin
		void'($urandom(71735));
		repeat (10) @(negedge sys_clk);
		rst_n = 1;
		chk({wreg, zero_flag, port_dirs, fwrite, done} === {9'h000, 24'hffffff, 17'h00000});
		ex(3, 24'h000000);
		ex(3, 24'h00ff00);
		ex(4, 24'hff00ff);
		ex(1, 24'h0000a5);
		ex(1, 24'h8012a5);
		ex(0, 24'h00ff00);
		for (int i = 4; i < 8; i++) ex(2, {1'b0, 7'(i), 16'h0000});
		rst_n = 0;
		repeat (2) @(negedge sys_clk);
		rst_n = 1;
		w = 0;
		z = 0;
		x = '1;
		chk({wreg, zero_flag, port_dirs, fwrite, done} === {9'h000, 24'hffffff, 17'h00000});
		ex(3, 24'h005a00);
		repeat (300) ex(3'($urandom_range(4, 1)), 24'($urandom));
		conclude;
	end
endmodule // nsx_exec_tb
